// ---- verilog/dac_wave_ctrl.sv ----
// Notes on behaviour
// - immediate mode: a latch write goes straight to the converter code.
// - immediate mode: update strobe held low continuously.
// - immediate mode: only the local latch feeds the converters.
// - the mode bit in control register selects the data path.
// - posted mode: samples buffered in a 2048-entry fifo.
// - serial path buffers one value ahead of each update.
// - posted: fifo and latch usable together; latch applied at next update.
// - serial path excludes fifo and latch paths.
// - posted values applied only on trigger from the selected source (counters 1,2,3,5 or external), the timer, or register.
// - data request readable in status register; host services it.
// - request from fifo not full or fifo under half full.
// - each streaming fifo update pops one entry, so request rises again.
// - streaming fifo mode or cyclic replay mode.
// - empty fifo at update while running stops updating and sets error flag.
// - cyclic mode pulses replay low at end of buffer, rewinding read point.
// - halt bit clear: cycle until triggering disabled, output keeps last value.
// - halt bit set: stop at next replay event.
// - cyclic, counted and pulsed modes need the whole buffer in the fifo.
// - counted mode counts replays and ends the sequence at the target.
// - status bit shows a terminated sequence.
// - pulsed mode: count replays, wait interval, restart until disabled or halted.
// - posted: timer trigger low pulse or update register strobe updates.
// - each channel takes a 16-bit code.
module dac_wave_ctrl #(
  parameter int unsigned DEPTH = dac_wave_pkg::FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] counter_out_n,
  input wire logic external_update_trigger_n,
  input wire logic timer_update_trigger_n,
  input wire logic serial_valid,
  input wire logic serial_channel,
  input wire logic [15:0] serial_code,
  output dac_wave_pkg::dac_pair_t dac_codes,
  output logic update_n,
  output logic fifo_replay_pulse_n,
  output logic waveform_data_request
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);

  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_chk
    $error("DEPTH must be a power of two of at least 4");
  end

  typedef enum {IDLE, RUN, GAP} seq_state_t;

  // ****************************************
  // register file
  // ****************************************
  logic [11:0] ctrl;
  logic [15:0] cycles;
  logic [31:0] interval;
  logic [15:0] latch0;
  logic [15:0] latch1;
  logic pend0;
  logic pend1;
  logic err_flag;
  logic done_flag;
  seq_state_t state;
  logic [AW:0] fifo_cnt;
  logic [AW:0] pos;
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [31:0] mem [DEPTH];
  logic [15:0] retx;
  logic [31:0] gap_cnt;
  logic [5:0] trig_prev;
  logic [15:0] ser_code;
  logic ser_ch;
  logic ser_full;

  wire posted = ctrl[dac_wave_pkg::CTRL_POSTED];
  wire half_mode = ctrl[dac_wave_pkg::CTRL_HALF];
  wire cyclic = ctrl[dac_wave_pkg::CTRL_CYCLIC];
  wire halt = ctrl[dac_wave_pkg::CTRL_HALT];
  wire trig_en = ctrl[dac_wave_pkg::CTRL_TRIG_EN];
  wire fifo_en = ctrl[dac_wave_pkg::CTRL_FIFO_EN];
  wire serial = ctrl[dac_wave_pkg::CTRL_SERIAL];
  wire [1:0] seq_mode = ctrl[dac_wave_pkg::CTRL_SEQ_LO +: 2];
  wire [2:0] src = ctrl[dac_wave_pkg::CTRL_SRC_LO +: 3];

  wire setup = psel && !penable;
  wire wr_acc = psel && penable && pwrite && pready;
  wire full = fifo_cnt == DEPTH_C;
  wire empty = fifo_cnt == '0;

  function automatic logic hit(input logic [7:0] off);
    hit = wr_acc && paddr == off;
  endfunction

  wire cmd_wr = hit(dac_wave_pkg::OFF_CMD);
  wire do_clear = cmd_wr && pwdata[dac_wave_pkg::CMD_CLEAR];
  wire do_start = cmd_wr && pwdata[dac_wave_pkg::CMD_START];

  // ****************************************
  // update trigger
  // ****************************************
  // sources are active-low pulses; an update fires on the falling edge only
  wire [5:0] trig_now = {timer_update_trigger_n, external_update_trigger_n, counter_out_n};
  wire [5:0] trig_fall = trig_prev & ~trig_now;
  wire sel_fall = (src == 3'(dac_wave_pkg::SRC_EXT)) ? trig_fall[4] : (src < 3'h4) && trig_fall[src[1:0]];
  wire hw_trig = state == RUN && trig_en && (sel_fall || trig_fall[5]);
  wire upd = posted && (hw_trig || (cmd_wr && pwdata[dac_wave_pkg::CMD_UPDATE]));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev <= 6'h3f;
    end else begin
      trig_prev <= trig_now;
    end
  end

  // ****************************************
  // fifo
  // ****************************************
  wire fifo_path = posted && fifo_en && !serial;
  wire push = hit(dac_wave_pkg::OFF_FIFO) && !full && !serial;
  wire fetch = upd && fifo_path && !empty;
  wire pop = fetch && !cyclic;
  wire cyc_rd = fetch && cyclic;
  wire end_buf = cyc_rd && (pos + 1'b1 == fifo_cnt);
  wire underflow = upd && fifo_path && empty;
  wire [31:0] head = mem[rp];

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wp] <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp <= '0;
      rp <= '0;
      pos <= '0;
      fifo_cnt <= '0;
    end else if (do_clear) begin
      wp <= '0;
      rp <= '0;
      pos <= '0;
      fifo_cnt <= '0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (end_buf) begin
        rp <= rp - AW'(fifo_cnt - 1'b1);
        pos <= '0;
      end else if (fetch) begin
        rp <= rp + 1'b1;
        pos <= pos + 1'b1;
      end
      if (do_start) begin
        pos <= '0;
      end
      fifo_cnt <= fifo_cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  // ****************************************
  // latch and serial holding registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_code <= '0;
      ser_ch <= 1'b0;
      ser_full <= 1'b0;
    end else if (serial_valid) begin
      ser_code <= serial_code;
      ser_ch <= serial_channel;
      ser_full <= 1'b1;
    end else if (upd && serial) begin
      ser_full <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch0 <= '0;
      latch1 <= '0;
      pend0 <= 1'b0;
      pend1 <= 1'b0;
    end else begin
      if (hit(dac_wave_pkg::OFF_LATCH0)) begin
        latch0 <= pwdata[15:0];
      end
      if (hit(dac_wave_pkg::OFF_LATCH1)) begin
        latch1 <= pwdata[15:0];
      end
      pend0 <= (pend0 && !upd) || (hit(dac_wave_pkg::OFF_LATCH0) && posted);
      pend1 <= (pend1 && !upd) || (hit(dac_wave_pkg::OFF_LATCH1) && posted);
    end
  end

  // ****************************************
  // converter codes
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_codes <= '0;
    end else if (!posted) begin
      if (hit(dac_wave_pkg::OFF_LATCH0)) begin
        dac_codes.ch0 <= pwdata[15:0];
      end
      if (hit(dac_wave_pkg::OFF_LATCH1)) begin
        dac_codes.ch1 <= pwdata[15:0];
      end
    end else if (upd && serial) begin
      if (ser_full && ser_ch) begin
        dac_codes.ch1 <= ser_code;
      end else if (ser_full) begin
        dac_codes.ch0 <= ser_code;
      end
    end else if (upd) begin
      // a pending latch value wins over the fifo word on its own channel
      if (pend0) begin
        dac_codes.ch0 <= latch0;
      end else if (fetch) begin
        dac_codes.ch0 <= head[15:0];
      end
      if (pend1) begin
        dac_codes.ch1 <= latch1;
      end else if (fetch) begin
        dac_codes.ch1 <= head[31:16];
      end
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  wire count_hit = retx + 1'b1 == cycles;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= IDLE;
      retx <= '0;
      gap_cnt <= '0;
    end else if (do_start) begin
      state <= RUN;
      retx <= '0;
    end else begin
      unique case (state)
        IDLE: begin
          retx <= '0;
        end
        RUN: begin
          if (underflow || !trig_en) begin
            state <= IDLE;
          end else if (end_buf && halt) begin
            state <= IDLE;
          end else if (end_buf && seq_mode != 2'(dac_wave_pkg::SEQ_FREE)) begin
            retx <= count_hit ? '0 : retx + 1'b1;
            if (count_hit && seq_mode == 2'(dac_wave_pkg::SEQ_PULSED)) begin
              state <= GAP;
              gap_cnt <= interval;
            end else if (count_hit) begin
              state <= IDLE;
            end
          end
        end
        GAP: begin
          gap_cnt <= gap_cnt - 1'b1;
          if (halt || !trig_en) begin
            state <= IDLE;
          end else if (gap_cnt <= 32'h1) begin
            state <= RUN;
          end
        end
      endcase
    end
  end

  wire seq_end = (state == RUN && end_buf && (halt || (count_hit && seq_mode == 2'(dac_wave_pkg::SEQ_COUNTED))))
    || (state == GAP && halt);
  wire st_wr = hit(dac_wave_pkg::OFF_STATUS);

  // flags are write-one-to-clear; a set in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_flag <= 1'b0;
      done_flag <= 1'b0;
    end else begin
      err_flag <= (underflow && state == RUN) || (err_flag && !(st_wr && pwdata[dac_wave_pkg::ST_ERR]));
      done_flag <= seq_end || (done_flag && !(st_wr && pwdata[dac_wave_pkg::ST_DONE]) && !do_start);
    end
  end

  // ****************************************
  // strobes and request
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      update_n <= 1'b0;
      fifo_replay_pulse_n <= 1'b1;
      waveform_data_request <= 1'b0;
    end else begin
      update_n <= posted ? !(upd && !underflow) : 1'b0;
      fifo_replay_pulse_n <= !end_buf;
      waveform_data_request <= fifo_path && !cyclic
        && (half_mode ? fifo_cnt < (DEPTH_C >> 1) : !full);
    end
  end

  // ****************************************
  // apb slave
  // ****************************************
  // read data is captured in setup, so every access completes with no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= dac_wave_pkg::CTRL_RESET;
      cycles <= dac_wave_pkg::CYCLES_RESET;
      interval <= dac_wave_pkg::INTERVAL_RESET;
    end else begin
      if (hit(dac_wave_pkg::OFF_CTRL)) begin
        ctrl <= pwdata[11:0];
      end
      if (hit(dac_wave_pkg::OFF_CYCLES)) begin
        cycles <= pwdata[15:0];
      end
      if (hit(dac_wave_pkg::OFF_INTERVAL)) begin
        interval <= pwdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        pslverr <= paddr[1:0] != 2'h0 || paddr > dac_wave_pkg::OFF_INTERVAL;
        prdata <= '0;
        if (!pwrite) begin
          unique case (paddr)
            dac_wave_pkg::OFF_CTRL: prdata <= {20'h0, ctrl};
            dac_wave_pkg::OFF_STATUS: prdata <= {26'h0, state != IDLE, full, empty, done_flag, err_flag,
                                                  waveform_data_request};
            dac_wave_pkg::OFF_LATCH0: prdata <= {16'h0, latch0};
            dac_wave_pkg::OFF_LATCH1: prdata <= {16'h0, latch1};
            dac_wave_pkg::OFF_CYCLES: prdata <= {16'h0, cycles};
            dac_wave_pkg::OFF_INTERVAL: prdata <= interval;
            default: prdata <= '0;
          endcase
        end
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_imm_strobe;
    !posted |=> !update_n;
  endproperty
  a_imm_strobe: assert property (p_imm_strobe) else $error("strobe not held low in immediate mode");

  property p_imm_route;
    (!posted && hit(dac_wave_pkg::OFF_LATCH0)) |=> dac_codes.ch0 == $past(pwdata[15:0]);
  endproperty
  a_imm_route: assert property (p_imm_route) else $error("latch write not routed to converter");

  property p_full_drop;
    (hit(dac_wave_pkg::OFF_FIFO) && full && !pop && !do_clear) |=> fifo_cnt == $past(fifo_cnt);
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("write while full changed fifo");

  property p_underflow;
    (underflow && state == RUN && !do_start) |=> err_flag && state == IDLE;
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow did not stop updating");

  property p_serial_excl;
    (serial && !do_clear) |=> fifo_cnt == $past(fifo_cnt) && rp == $past(rp);
  endproperty
  a_serial_excl: assert property (p_serial_excl) else $error("fifo active in serial mode");

  sequence s_halt_end;
    state == RUN && end_buf && halt && !do_start && !underflow;
  endsequence
  property p_halt;
    s_halt_end |=> state == IDLE && done_flag && !fifo_replay_pulse_n;
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not end at buffer end");

  sequence s_burst_end;
    state == RUN && end_buf && count_hit && !halt && trig_en && !underflow && !do_start
      && seq_mode == 2'(dac_wave_pkg::SEQ_PULSED);
  endsequence
  property p_pulsed;
    s_burst_end |=> state == GAP;
  endproperty
  a_pulsed: assert property (p_pulsed) else $error("burst end did not enter interval");

  property p_request;
    (fifo_path && !cyclic && !half_mode && !full) |=> waveform_data_request;
  endproperty
  a_request: assert property (p_request) else $error("request missing while fifo not full");

  property p_posted_only_on_trigger;
    (posted && !upd) |=> update_n;
  endproperty
  a_posted_only_on_trigger: assert property (p_posted_only_on_trigger) else $error("update without trigger");
endmodule

// ---- verilog/dac_wave_pkg.sv ----
package dac_wave_pkg;
  localparam int unsigned FIFO_DEPTH = 2048;
  localparam int unsigned CODE_W = 16;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_FIFO = 8'h08;
  localparam logic [7:0] OFF_LATCH0 = 8'h0c;
  localparam logic [7:0] OFF_LATCH1 = 8'h10;
  localparam logic [7:0] OFF_CMD = 8'h14;
  localparam logic [7:0] OFF_CYCLES = 8'h18;
  localparam logic [7:0] OFF_INTERVAL = 8'h1c;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int CTRL_POSTED = 0;
  localparam int CTRL_HALF = 1;
  localparam int CTRL_CYCLIC = 2;
  localparam int CTRL_HALT = 3;
  localparam int CTRL_TRIG_EN = 4;
  localparam int CTRL_FIFO_EN = 5;
  localparam int CTRL_SERIAL = 6;
  localparam int CTRL_SEQ_LO = 7;
  localparam int CTRL_SRC_LO = 9;
  localparam logic [11:0] CTRL_RESET = 12'h000;
  localparam logic [15:0] CYCLES_RESET = 16'h0001;
  localparam logic [31:0] INTERVAL_RESET = 32'h0000_0001;

  localparam int ST_REQ = 0;
  localparam int ST_ERR = 1;
  localparam int ST_DONE = 2;
  localparam int ST_EMPTY = 3;
  localparam int ST_FULL = 4;
  localparam int ST_RUN = 5;

  localparam int CMD_UPDATE = 0;
  localparam int CMD_CLEAR = 1;
  localparam int CMD_START = 2;

  typedef struct packed {
    logic [15:0] ch1;
    logic [15:0] ch0;
  } dac_pair_t;

  typedef enum logic [1:0] {SEQ_FREE, SEQ_COUNTED, SEQ_PULSED} seq_mode_t;
  typedef enum logic [2:0] {SRC_CNT1, SRC_CNT2, SRC_CNT3, SRC_CNT5, SRC_EXT} trig_src_t;
endpackage

// ---- tb/trig_source.sv ----
// ****
// counter, external and timer pulse source
// ****
module trig_source (
  input wire logic pclk,
  output logic [3:0] counter_out_n,
  output logic external_update_trigger_n,
  output logic timer_update_trigger_n,
  output logic serial_valid,
  output logic serial_channel,
  output logic [15:0] serial_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] lines = 6'h3f;
  logic [16:0] idle_pat = 17'h00000;
  assign counter_out_n = lines[3:0];
  assign external_update_trigger_n = lines[4];
  assign timer_update_trigger_n = lines[5];
  logic ser_v = 1'b0;
  logic [16:0] ser_word = 17'h00000;
  assign serial_valid = ser_v;
  // idle serial lines move every cycle so a stale value cannot pass
  assign {serial_channel, serial_code} = ser_v ? ser_word : idle_pat;
  always @(posedge pclk) begin
    idle_pat <= 17'($urandom);
  end
  // low for two cycles, then high long enough for the next falling edge
  task automatic pulse(input int idx);
    @(posedge pclk);
    lines[idx] <= 1'b0;
    repeat (2) @(posedge pclk);
    lines[idx] <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask
  // one serial value, valid for a single cycle
  task automatic send(input logic ch, input logic [15:0] code);
    @(posedge pclk);
    ser_word <= {ch, code};
    ser_v <= 1'b1;
    @(posedge pclk);
    ser_v <= 1'b0;
  endtask
endmodule

// ---- tb/dac_waveform_update_control_tb_top.sv ----
module dac_waveform_update_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] counter_out_n;
  logic external_update_trigger_n;
  logic timer_update_trigger_n;
  logic serial_valid;
  logic serial_channel;
  logic [15:0] serial_code;
  dac_wave_pkg::dac_pair_t dac_codes;
  logic update_n;
  logic fifo_replay_pulse_n;
  logic waveform_data_request;
  int n_mismatch = 0;
  int cmp_count = 0;
  int replay_cnt = 0;
  logic posted_mon = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] rd;
  logic err;
  logic [31:0] w;
  logic [31:0] words[17];

  dac_wave_ctrl #(.DEPTH(16)) dac_wave_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .counter_out_n(counter_out_n),
    .external_update_trigger_n(external_update_trigger_n), .timer_update_trigger_n(timer_update_trigger_n),
    .serial_valid(serial_valid), .serial_channel(serial_channel), .serial_code(serial_code),
    .dac_codes(dac_codes), .update_n(update_n), .fifo_replay_pulse_n(fifo_replay_pulse_n),
    .waveform_data_request(waveform_data_request));
  trig_source trig_source_inst (.pclk(pclk), .counter_out_n(counter_out_n),
    .external_update_trigger_n(external_update_trigger_n), .timer_update_trigger_n(timer_update_trigger_n),
    .serial_valid(serial_valid), .serial_channel(serial_channel), .serial_code(serial_code));

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  // ****
  // shared tasks
  // ****
  task automatic complete_run();
    $display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // master holds the whole request until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask
  task automatic trig(input int k);
    trig_source_inst.pulse(k);
  endtask

  // ****
  // output watcher: each posted update takes the oldest expected code pair
  // ****
  // sampled mid-cycle so registered outputs have settled
  always @(negedge pclk) begin
    if (fifo_replay_pulse_n === 1'b0) replay_cnt++;
    if (presetn === 1'b1 && posted_mon && update_n === 1'b0) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, dac_codes, 32'h0);
      end else check(dac_codes, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    complete_run();
  end

  // ****
  // main sequence
  // ****
  initial begin
    void'($urandom(61));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rchk(dac_wave_pkg::OFF_CTRL, 32'hfff, {20'h0, dac_wave_pkg::CTRL_RESET});
    rchk(dac_wave_pkg::OFF_CYCLES, 32'hffff, {16'h0, dac_wave_pkg::CYCLES_RESET});
    rchk(dac_wave_pkg::OFF_INTERVAL, 32'hffffffff, dac_wave_pkg::INTERVAL_RESET);
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, err}, 32'h1);
    // immediate: latch goes straight through, fifo and triggers have no say
    w = $urandom;
    wr(dac_wave_pkg::OFF_LATCH0, {16'h0, w[15:0]});
    wr(dac_wave_pkg::OFF_LATCH1, {16'h0, w[31:16]});
    wr(dac_wave_pkg::OFF_FIFO, ~w);
    trig(5);
    check(dac_codes, w);
    check({31'h0, update_n}, 32'h0);
    // half-full request: below eight of sixteen only
    wr(dac_wave_pkg::OFF_CMD, 32'h2);
    wr(dac_wave_pkg::OFF_CTRL, 32'h23);
    for (int i = 0; i < 7; i++) wr(dac_wave_pkg::OFF_FIFO, $urandom);
    rchk(dac_wave_pkg::OFF_STATUS, 32'h1, 32'h1);
    check({31'h0, waveform_data_request}, 32'h1);
    wr(dac_wave_pkg::OFF_FIFO, $urandom);
    rchk(dac_wave_pkg::OFF_STATUS, 32'h1, 32'h0);
    // streaming: fill past full, then every trigger source in turn
    wr(dac_wave_pkg::OFF_CMD, 32'h2);
    wr(dac_wave_pkg::OFF_CTRL, 32'h31);
    posted_mon = 1'b1;
    rchk(dac_wave_pkg::OFF_STATUS, 32'h19, 32'h09);
    for (int i = 0; i <= 16; i++) begin
      words[i] = $urandom;
      wr(dac_wave_pkg::OFF_FIFO, words[i]);
      if (i < 16) exp_q.push_back(words[i]);
    end
    rchk(dac_wave_pkg::OFF_STATUS, 32'h11, 32'h10);
    wr(dac_wave_pkg::OFF_CMD, 32'h4);
    for (int i = 0; i < 16; i++) begin
      if (i % 7 < 5) wr(dac_wave_pkg::OFF_CTRL, 32'h31 | ((i % 7) << 9));
      if (i % 7 == 6) wr(dac_wave_pkg::OFF_CMD, 32'h1);
      else trig(i % 7);
      if (i == 0) rchk(dac_wave_pkg::OFF_STATUS, 32'h1, 32'h1);
    end
    w = $urandom;
    wr(dac_wave_pkg::OFF_LATCH0, {16'h0, w[15:0]});
    wr(dac_wave_pkg::OFF_FIFO, ~w);
    exp_q.push_back({~w[31:16], w[15:0]});
    trig(5);
    trig(5);
    rchk(dac_wave_pkg::OFF_STATUS, 32'h2, 32'h2);
    wr(dac_wave_pkg::OFF_FIFO, w);
    trig(5);
    // cyclic with graceful halt: one pass then stop at the replay
    wr(dac_wave_pkg::OFF_CMD, 32'h2);
    wr(dac_wave_pkg::OFF_STATUS, 32'h6);
    wr(dac_wave_pkg::OFF_CTRL, 32'h3d);
    for (int i = 0; i < 3; i++) wr(dac_wave_pkg::OFF_FIFO, words[i]);
    for (int i = 0; i < 3; i++) exp_q.push_back(words[i]);
    wr(dac_wave_pkg::OFF_CMD, 32'h4);
    replay_cnt = 0;
    repeat (5) trig(5);
    check(32'(replay_cnt), 32'h1);
    rchk(dac_wave_pkg::OFF_STATUS, 32'h20, 32'h0);
    // counted cycles: two passes of two words, then done
    wr(dac_wave_pkg::OFF_CMD, 32'h2);
    wr(dac_wave_pkg::OFF_STATUS, 32'h6);
    wr(dac_wave_pkg::OFF_CYCLES, 32'h2);
    wr(dac_wave_pkg::OFF_CTRL, 32'hb5);
    for (int i = 0; i < 2; i++) wr(dac_wave_pkg::OFF_FIFO, words[i]);
    for (int i = 0; i < 4; i++) exp_q.push_back(words[i % 2]);
    wr(dac_wave_pkg::OFF_CMD, 32'h4);
    repeat (6) trig(5);
    rchk(dac_wave_pkg::OFF_STATUS, 32'h24, 32'h04);
    // pulsed: one-word burst, gap, restart on its own
    wr(dac_wave_pkg::OFF_CMD, 32'h2);
    wr(dac_wave_pkg::OFF_STATUS, 32'h6);
    wr(dac_wave_pkg::OFF_CYCLES, 32'h1);
    wr(dac_wave_pkg::OFF_INTERVAL, 32'h4);
    wr(dac_wave_pkg::OFF_CTRL, 32'h135);
    wr(dac_wave_pkg::OFF_FIFO, words[5]);
    wr(dac_wave_pkg::OFF_CMD, 32'h4);
    for (int i = 0; i < 3; i++) begin
      exp_q.push_back(words[5]);
      trig(5);
      repeat (10) @(posedge pclk);
    end
    // cyclic free running: keeps replaying until triggering is switched off
    wr(dac_wave_pkg::OFF_CMD, 32'h2);
    wr(dac_wave_pkg::OFF_CTRL, 32'h35);
    wr(dac_wave_pkg::OFF_FIFO, words[6]);
    wr(dac_wave_pkg::OFF_FIFO, words[7]);
    for (int i = 0; i < 5; i++) exp_q.push_back(words[6 + i % 2]);
    wr(dac_wave_pkg::OFF_CMD, 32'h4);
    replay_cnt = 0;
    repeat (5) trig(5);
    check(32'(replay_cnt), 32'h2);
    wr(dac_wave_pkg::OFF_CTRL, 32'h25);
    trig(5);
    check(dac_codes, words[6]);
    rchk(dac_wave_pkg::OFF_STATUS, 32'h20, 32'h0);
    // serial path: one value held per update, fifo writes refused
    wr(dac_wave_pkg::OFF_CMD, 32'h2);
    wr(dac_wave_pkg::OFF_CTRL, 32'h71);
    wr(dac_wave_pkg::OFF_CMD, 32'h4);
    w = $urandom;
    trig_source_inst.send(1'b1, w[31:16]);
    exp_q.push_back({w[31:16], words[6][15:0]});
    trig(5);
    wr(dac_wave_pkg::OFF_FIFO, w);
    rchk(dac_wave_pkg::OFF_STATUS, 32'h8, 32'h8);
    trig_source_inst.send(1'b0, w[15:0]);
    exp_q.push_back(w);
    trig(5);
    repeat (4) @(posedge pclk);
    check(32'(exp_q.size()), 32'h0);
    complete_run();
  end
endmodule
